/* afe_serial_pkg.sv */
package afe_serial_pkg;

  // serial word geometry
  localparam int WORD_W    = 16;          // every link word is this wide
  localparam int CNT_W     = 4;           // bit counter width for one word
  localparam int NUM_REGS  = 8;           // control registers a .. h
  localparam int REG_W     = 8;           // width of one control register
  localparam int IDX_W     = 3;           // control register index width
  localparam int CADDR_W   = 3;           // device address field width

  // control word layout (flag, address, direction, register, data)
  localparam int CW_FLAG_BIT = 15;
  localparam int CW_ADDR_MSB = 14;
  localparam int CW_ADDR_LSB = 12;
  localparam int CW_RW_BIT   = 11;
  localparam int CW_REG_MSB  = 10;
  localparam int CW_REG_LSB  = 8;
  localparam int CW_DAT_MSB  = 7;

  // control register indices and field positions
  localparam logic [IDX_W-1:0] IDX_CRA = 3'h0;
  localparam logic [IDX_W-1:0] IDX_CRB = 3'h1;
  localparam int CRA_PGM_BIT = 0;         // program_data_select
  localparam int CRA_MM_BIT  = 1;         // mixed_mode_bit
  localparam int CRA_RST_BIT = 7;         // software reset
  localparam int CRB_DR_LSB  = 0;         // sample rate field, 2 bits
  localparam int CRB_SCD_LSB = 2;         // bit clock divider field, 2 bits
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;

  // timing counts, in divided_master_clock cycles except the divider, which is in system clocks
  localparam int DIVIDED_MASTER_CLOCK_DIV_DEF          = 4;     // system clocks per divided_master_clock cycle
  localparam logic [2:0]  RESET_DIVIDED_MASTER_CLOCK   = 3'h4;  // reset length
  localparam logic [11:0] SAMPLE_BASE   = 12'h800; // 2048 divided_master_clock per sample
  localparam logic [2:0]  SCLK_BASE_HALF = 3'h4; // half bit clock, slowest rate

  // wishbone byte offsets
  localparam logic [7:0] WB_CTRL_BASE = 8'h00;   // a .. h, one word each
  localparam logic [7:0] WB_CTRL_LAST = 8'h1C;
  localparam logic [7:0] WB_STATUS    = 8'h20;
  localparam logic [7:0] WB_SAMPLE    = 8'h24;

  typedef enum logic [1:0] {
    MODE_PROGRAM = 2'b00,
    MODE_DATA    = 2'b01,
    MODE_MIXED   = 2'b10
  } mode_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SYNC  = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_t;

endpackage : afe_serial_pkg

/* tick_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int DIV = 4                   // clocks per tick, at least 2
) (
  input  wire logic clk_i,                // system clock
  input  wire logic rst_i,                // synchronous reset, active high
  output logic      tick_o                // one-cycle pulse every DIV clocks
);

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_ff;                  // free running phase

  // wraps at LAST and flags the wrap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_ff == LAST);
      cnt_ff <= (cnt_ff == LAST) ? '0 : cnt_ff + 1'b1;
    end
  end

endmodule : tick_divider
`default_nettype wire

/* word_receiver.sv */
`timescale 1ns/1ps
`default_nettype none
module word_receiver
  import afe_serial_pkg::*;
(
  input  wire logic              clk_i,      // system clock
  input  wire logic              rst_i,      // synchronous reset
  input  wire logic              sample_i,   // bit clock sampling event
  input  wire logic              fs_i,       // synchronised input frame sync
  input  wire logic              bit_i,      // synchronised serial data
  output logic [WORD_W-1:0]      word_o,     // last complete word
  output logic                   valid_o     // one-cycle pulse per word
);

  logic [WORD_W-1:0] shift_ff;            // assembly register
  logic [CNT_W-1:0]  cnt_ff;              // bits taken so far
  logic              active_ff;           // inside a word

  // frame sync arms, then sixteen bits msb first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_ff  <= '0;
      cnt_ff    <= '0;
      active_ff <= 1'b0;
      word_o    <= '0;
      valid_o   <= 1'b0;
    end else begin
      valid_o <= 1'b0;
      if (sample_i) begin
        if (active_ff) begin
          shift_ff <= {shift_ff[WORD_W-2:0], bit_i};
          cnt_ff   <= cnt_ff + 1'b1;
          if (cnt_ff == CNT_W'(WORD_W - 1)) begin
            word_o    <= {shift_ff[WORD_W-2:0], bit_i};
            valid_o   <= 1'b1;
            // sync during the last bit chains the next word
            active_ff <= fs_i;
            cnt_ff    <= '0;
          end
        end else if (fs_i) begin
          active_ff <= 1'b1;
          cnt_ff    <= '0;
        end
      end
    end
  end

endmodule : word_receiver
`default_nettype wire

/* afe_serial_mode_control.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - config changes only in program or mixed mode
// - all link words are sixteen bits
// - program mode words are control words
// - address zero write word writes own register; a read word is ignored
// - nonzero address decremented and forwarded out
// - enabled port pulses output frame sync per sample
// - default sample rate 2048 divided_master_clock until programmed
// - program mode output words carry the sample word unchanged
// - select one, mixed zero enters data mode
// - data mode discards every input word
// - data mode locks registers until hardware reset
// - mixed mode msb flags fifteen control bits
// - both bits one enters mixed mode
// - mixed mode sample words have msb zero
// - frame sync high one bit before word
// - device drives the serial bit clock
// - any reset returns to program mode
// - both resets clear registers, four divided_master_clock cycles
module afe_serial_mode_control
  import afe_serial_pkg::*;
#(
  parameter int DIVIDED_MASTER_CLOCK_DIV = DIVIDED_MASTER_CLOCK_DIV_DEF     // system clocks per divided_master_clock cycle
) (
  input  wire logic        SYS_CLK_I,         // 200 MHz system clock
  input  wire logic        SYS_RST_I,         // synchronous reset, active high
  input  wire logic        FE_RESET_N_I,      // front_end_reset_pin, active low
  input  wire logic        SERIAL_PORT_ENABLE_I, // serial_port_enable_pin
  input  wire logic        SERIAL_DATA_IN_I,  // serial_data_in
  input  wire logic        SERIAL_IN_FS_I,    // serial_in_frame_sync
  output logic             SERIAL_CLK_O,      // bit clock toward the host
  output logic             SERIAL_DATA_OUT_O, // serial_data_out
  output logic             SERIAL_OUT_FS_O,   // serial_out_frame_sync
  input  wire logic        WB_CYC_I,          // wishbone cycle
  input  wire logic        WB_STB_I,          // wishbone strobe
  input  wire logic        WB_WE_I,           // wishbone write enable
  input  wire logic [7:0]  WB_ADR_I,          // wishbone byte address
  input  wire logic [3:0]  WB_SEL_I,          // wishbone byte lanes
  input  wire logic [31:0] WB_DAT_I,          // wishbone write data
  output logic [31:0]      WB_DAT_O,          // wishbone read data
  output logic             WB_ACK_O           // wishbone acknowledge
);

  // mode decode from control register a
  function automatic mode_t mode_of(input logic [REG_W-1:0] control_register_a);
    if (!control_register_a[CRA_PGM_BIT])     return MODE_PROGRAM;
    else if (control_register_a[CRA_MM_BIT])  return MODE_MIXED;
    else                       return MODE_DATA;
  endfunction : mode_of

  // half bit clock in divided_master_clock cycles, never below one
  function automatic logic [2:0] half_of(input logic [1:0] scd);
    logic [2:0] h;
    h = SCLK_BASE_HALF >> scd;
    return (h == 3'h0) ? 3'h1 : h;
  endfunction : half_of

  // pin synchronisers -----------------------------------------------
  logic [3:0] meta_ff;                        // first stage, read by sync_ff only
  logic [3:0] sync_ff;                        // second stage
  logic       fe_rst_n_s;                     // synchronised reset pin
  logic       port_en_s;                      // synchronised enable pin
  logic       sdi_s;                          // synchronised data in
  logic       serial_in_frame_sync_s;                        // synchronised frame sync in

  // all four pins come from the far side, two flops each
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      meta_ff <= 4'h0;
      sync_ff <= 4'h0;
    end else begin
      meta_ff <= {SERIAL_IN_FS_I, SERIAL_DATA_IN_I, SERIAL_PORT_ENABLE_I, FE_RESET_N_I};
      sync_ff <= meta_ff;
    end
  end
  assign fe_rst_n_s = sync_ff[0];
  assign port_en_s  = sync_ff[1];
  assign sdi_s      = sync_ff[2];
  assign serial_in_frame_sync_s    = sync_ff[3];

  // divided master clock --------------------------------------------
  logic divided_master_clock_tick;                           // one pulse per divided_master_clock cycle

  tick_divider #(
    .DIV    (DIVIDED_MASTER_CLOCK_DIV)
  ) u_divided_master_clock (
    .clk_i  (SYS_CLK_I),
    .rst_i  (SYS_RST_I),
    .tick_o (divided_master_clock_tick)
  );

  // register file and reset sequencing ------------------------------
  logic [NUM_REGS-1:0][REG_W-1:0] regs_ff;    // control registers a .. h
  logic [2:0]  rst_cnt_ff;                    // divided_master_clock cycles of reset left
  logic        soft_rst_req;                  // software reset bit written
  logic        rst_req;                       // any front end reset request
  logic        afe_in_reset;                  // front end held in reset
  logic        reg_we;                        // accepted register write
  logic [IDX_W-1:0] reg_idx;                  // register addressed by word
  logic [REG_W-1:0] reg_data;                 // data carried by word
  mode_t       mode;                          // current operating mode

  assign mode         = mode_of(regs_ff[IDX_CRA]);
  assign rst_req      = !fe_rst_n_s || soft_rst_req;
  assign afe_in_reset = (rst_cnt_ff != 3'h0);

  // a held pin keeps reloading, so the length counts from release
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I)
      rst_cnt_ff <= RESET_DIVIDED_MASTER_CLOCK;
    else if (rst_req)
      rst_cnt_ff <= RESET_DIVIDED_MASTER_CLOCK;
    else if (afe_in_reset && divided_master_clock_tick)
      rst_cnt_ff <= rst_cnt_ff - 3'h1;
  end

  // registers clear throughout reset, otherwise take accepted writes
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I || afe_in_reset) begin
      regs_ff <= {NUM_REGS{REG_RESET}};
    end else if (reg_we) begin
      regs_ff[reg_idx] <= reg_data;
    end
  end

  // serial bit clock ------------------------------------------------
  logic [2:0] phase_ff;                       // divided_master_clock cycles into half period
  logic [2:0] half_len;                       // selected half period
  logic       toggle;                         // bit clock edge this cycle
  logic       rise_ev;                        // bit clock about to rise
  logic       fall_ev;                        // bit clock about to fall
  logic       link_on;                        // port enabled and out of reset

  assign link_on  = port_en_s && !afe_in_reset;
  assign half_len = half_of(regs_ff[IDX_CRB][CRB_SCD_LSB +: 2]);
  assign toggle   = link_on && divided_master_clock_tick && (phase_ff >= half_len - 3'h1);
  assign rise_ev  = toggle && !SERIAL_CLK_O;
  assign fall_ev  = toggle && SERIAL_CLK_O;

  // the device makes the bit clock; it parks low while disabled
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I || !link_on) begin
      phase_ff     <= 3'h0;
      SERIAL_CLK_O <= 1'b0;
    end else if (toggle) begin
      phase_ff     <= 3'h0;
      SERIAL_CLK_O <= !SERIAL_CLK_O;
    end else if (divided_master_clock_tick) begin
      phase_ff     <= phase_ff + 3'h1;
    end
  end

  // sample timer ----------------------------------------------------
  logic [11:0] smp_cnt_ff;                    // divided_master_clock cycles into the sample
  logic [11:0] smp_last;                      // last count of a sample period
  logic        sample_ev;                     // one output sample event

  // cleared rate field gives the slow 2048 default after reset
  assign smp_last  = (SAMPLE_BASE >> regs_ff[IDX_CRB][CRB_DR_LSB +: 2]) - 12'h001;
  assign sample_ev = link_on && divided_master_clock_tick && (smp_cnt_ff >= smp_last);

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I || !link_on)
      smp_cnt_ff <= 12'h000;
    else if (sample_ev)
      smp_cnt_ff <= 12'h000;
    else if (divided_master_clock_tick)
      smp_cnt_ff <= smp_cnt_ff + 12'h001;
  end

  // receive path ----------------------------------------------------
  logic [WORD_W-1:0] rx_word;                 // assembled input word
  logic              rx_valid;                // word complete pulse

  // input sampled on the falling bit clock, msb first
  word_receiver u_rx (
    .clk_i    (SYS_CLK_I),
    .rst_i    (SYS_RST_I || afe_in_reset),
    .sample_i (fall_ev),
    .fs_i     (serial_in_frame_sync_s),
    .bit_i    (sdi_s),
    .word_o   (rx_word),
    .valid_o  (rx_valid)
  );

  // word interpretation ---------------------------------------------
  logic             is_ctrl;                  // word carries control info
  logic [CADDR_W-1:0] rx_addr;                // device address field
  logic             fwd_gen;                  // word must travel onward
  logic             fwd_pend_ff;              // forwarded word waiting to go
  logic [WORD_W-1:0] fwd_word_ff;             // modified word to send on

  // data mode drops everything; mixed mode needs the flag bit
  assign is_ctrl  = rx_valid && ((mode == MODE_PROGRAM) ||
                    ((mode == MODE_MIXED) && rx_word[CW_FLAG_BIT]));
  assign rx_addr  = rx_word[CW_ADDR_MSB:CW_ADDR_LSB];
  assign reg_we   = is_ctrl && (rx_addr == 3'h0) && !rx_word[CW_RW_BIT];
  assign reg_idx  = rx_word[CW_REG_MSB:CW_REG_LSB];
  assign reg_data = rx_word[CW_DAT_MSB:0];
  assign fwd_gen  = is_ctrl && (rx_addr != 3'h0);
  assign soft_rst_req = reg_we && (reg_idx == IDX_CRA) && reg_data[CRA_RST_BIT];

  // transmit path ---------------------------------------------------
  tx_state_t         tx_state_ff;             // output word sequencer
  logic [WORD_W-1:0] tx_shift_ff;             // outgoing bits
  logic [CNT_W-1:0]  tx_cnt_ff;               // bits sent so far
  logic              start_pend_ff;           // sample event not yet served
  logic              tx_start;                // a word begins this edge
  logic              tx_take_fwd;             // the word is a forwarded one
  logic [WORD_W-1:0] sample_ff;               // conversion result from software
  logic [WORD_W-1:0] out_word;                // next sample word to send

  // program mode output is don't-care data; mixed clears the msb
  assign out_word    = (mode == MODE_MIXED) ? {1'b0, sample_ff[WORD_W-2:0]}
                                            : sample_ff;
  assign tx_start    = rise_ev && (tx_state_ff == TX_IDLE) && (start_pend_ff || fwd_pend_ff);
  assign tx_take_fwd = tx_start && fwd_pend_ff;

  // new sample events win over the clear at the start of a word
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I || !link_on)
      start_pend_ff <= 1'b0;
    else if (sample_ev)
      start_pend_ff <= 1'b1;
    else if (tx_start && !tx_take_fwd)
      start_pend_ff <= 1'b0;
  end

  // forwarded words go out ahead of the next sample word
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I || afe_in_reset) begin
      fwd_pend_ff <= 1'b0;
      fwd_word_ff <= '0;
    end else if (fwd_gen) begin
      fwd_pend_ff <= 1'b1;
      fwd_word_ff <= {rx_word[CW_FLAG_BIT], rx_addr - 3'h1,
                      rx_word[CW_RW_BIT:0]};
    end else if (tx_take_fwd) begin
      fwd_pend_ff <= 1'b0;
    end
  end

  // sync bit, then sixteen data bits, all on rising bit clock
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I || !link_on) begin
      tx_state_ff       <= TX_IDLE;
      tx_shift_ff       <= '0;
      tx_cnt_ff         <= '0;
      SERIAL_OUT_FS_O   <= 1'b0;
      SERIAL_DATA_OUT_O <= 1'b0;
    end else if (rise_ev) begin
      case (tx_state_ff)
        TX_IDLE: begin
          if (tx_start) begin
            SERIAL_OUT_FS_O <= 1'b1;
            tx_shift_ff     <= tx_take_fwd ? fwd_word_ff : out_word;
            tx_state_ff     <= TX_SYNC;
          end
        end
        TX_SYNC: begin
          SERIAL_OUT_FS_O   <= 1'b0;
          SERIAL_DATA_OUT_O <= tx_shift_ff[WORD_W-1];
          tx_shift_ff       <= {tx_shift_ff[WORD_W-2:0], 1'b0};
          tx_cnt_ff         <= '0;
          tx_state_ff       <= TX_SHIFT;
        end
        TX_SHIFT: begin
          if (tx_cnt_ff == CNT_W'(WORD_W - 1)) begin
            SERIAL_DATA_OUT_O <= 1'b0;
            tx_state_ff       <= TX_IDLE;
          end else begin
            SERIAL_DATA_OUT_O <= tx_shift_ff[WORD_W-1];
            tx_shift_ff       <= {tx_shift_ff[WORD_W-2:0], 1'b0};
            tx_cnt_ff         <= tx_cnt_ff + 1'b1;
          end
        end
        default: tx_state_ff <= TX_IDLE;
      endcase
    end
  end

  // wishbone slave --------------------------------------------------
  logic        wb_req;                        // new request this cycle
  logic [31:0] rd_data;                       // decoded read value

  assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;

  // read decode; unmapped offsets read zero but still acknowledge
  always_comb begin
    rd_data = 32'h0000_0000;
    if (WB_ADR_I <= WB_CTRL_LAST && WB_ADR_I[1:0] == 2'h0) begin
      rd_data = {24'h00_0000, regs_ff[WB_ADR_I[4:2]]};
    end else if (WB_ADR_I == WB_STATUS) begin
      rd_data = {26'h000_0000, fwd_pend_ff, afe_in_reset,
                 (tx_state_ff != TX_IDLE), port_en_s, mode};
    end else if (WB_ADR_I == WB_SAMPLE) begin
      rd_data = {16'h0000, sample_ff};
    end
  end

  // one wait state, ack drops the cycle after it was given
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= wb_req;
      if (wb_req && !WB_WE_I)
        WB_DAT_O <= rd_data;
    end
  end

  // software supplies the conversion word; control regs are serial-only
  // the write lands at the edge where the master sees ack, so a held request counts once
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      sample_ff <= 16'h0000;
    end else if (WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I && WB_ADR_I == WB_SAMPLE) begin
      if (WB_SEL_I[0])
        sample_ff[7:0] <= WB_DAT_I[7:0];
      if (WB_SEL_I[1])
        sample_ff[15:8] <= WB_DAT_I[15:8];
    end
  end

  // checks ----------------------------------------------------------
  logic [3:0] rst_ticks_ff;                   // divided_master_clock cycles seen in reset

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I || rst_req)
      rst_ticks_ff <= 4'h0;
    else if (afe_in_reset && divided_master_clock_tick && rst_ticks_ff != 4'hF)
      rst_ticks_ff <= rst_ticks_ff + 4'h1;
  end

  a_cfg_mode_gate: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    reg_we |-> (mode != MODE_DATA))
    else $error("register write accepted in data mode");

  a_own_addr_write: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (reg_we && !soft_rst_req && !rst_req) |=> (regs_ff[$past(reg_idx)] == $past(reg_data)))
    else $error("own control word not stored");

  a_fwd_decrement: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (fwd_gen && !afe_in_reset) |=>
      (fwd_pend_ff && fwd_word_ff[CW_ADDR_MSB:CW_ADDR_LSB] == $past(rx_addr) - 3'h1))
    else $error("forwarded address not decremented");

  a_data_discard: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (rx_valid && mode == MODE_DATA) |-> (!reg_we && !fwd_gen && !soft_rst_req))
    else $error("input word acted on in data mode");

  a_data_lock: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (mode == MODE_DATA && fe_rst_n_s) |=> ($stable(regs_ff) || afe_in_reset))
    else $error("registers changed in data mode");

  a_mixed_msb_zero: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (tx_start && !tx_take_fwd && mode == MODE_MIXED) |=> !tx_shift_ff[WORD_W-1])
    else $error("mixed mode sample word msb set");

  a_fs_one_bit: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    $fell(SERIAL_OUT_FS_O) && link_on |-> ($past(rise_ev) && tx_state_ff == TX_SHIFT))
    else $error("frame sync not one bit clock long");

  a_reset_program: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    afe_in_reset |=> (mode == MODE_PROGRAM))
    else $error("reset did not return to program mode");

  a_reset_length: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    $fell(afe_in_reset) |-> (rst_ticks_ff == 4'h4 && regs_ff == '0))
    else $error("front end reset not four divided_master_clock cycles");

endmodule : afe_serial_mode_control
`default_nettype wire

/* host_port_model.sv */
`timescale 1ns/1ps
`default_nettype none
// host serial port, directly coupled: its syncs follow the device output sync
module host_port_model (
  input  wire logic        clk_i,      // system clock, used to see bit clock rises
  input  wire logic        sclk_i,     // bit clock from the device
  input  wire logic        fs_i,       // device output frame sync
  input  wire logic        sdo_i,      // device serial data
  input  wire logic        go_i,       // send tx_i in the next frame
  input  wire logic [15:0] tx_i,       // word to send
  output logic             sdi_o,      // host serial data
  output logic             ifs_o,      // host transmit frame sync, made by the host
  output logic             rx_valid_o, // one-cycle pulse per received word
  output logic             sent_o,     // one-cycle pulse when tx_i went out
  output logic [15:0]      rx_o        // last received word
);
  logic        sclk_q = 1'b0;          // bit clock one system clock ago
  logic [4:0]  cnt = 5'd0;             // bits still due in this frame
  logic [15:0] sh = 16'h0;             // transmit shifter
  logic        txf = 1'b0;             // this frame carries our word
  initial sdi_o = 1'b0;
  initial ifs_o = 1'b0;
  initial rx_valid_o = 1'b0;
  initial sent_o = 1'b0;
  initial rx_o = 16'h0;
  // act on the system edge just after each rise, when the device outputs have settled
  always @(posedge clk_i) begin
    sclk_q <= sclk_i;
    rx_valid_o <= 1'b0;
    sent_o <= 1'b0;
    if (sclk_i && !sclk_q) begin
      ifs_o <= fs_i && go_i;
      if (fs_i) begin
        cnt <= 5'd16;
        txf <= go_i;
        sh <= tx_i;
        sdi_o <= ~sdi_o;
      end else if (cnt != 5'd0) begin
        rx_o <= {rx_o[14:0], sdo_i};
        cnt <= cnt - 5'd1;
        rx_valid_o <= (cnt == 5'd1);
        sent_o <= (cnt == 5'd1) && txf;
        sdi_o <= txf ? sh[15] : ~sdi_o;
        sh <= {sh[14:0], 1'b0};
      end else begin
        // idle line toggles so no stale bit can pass for data
        sdi_o <= ~sdi_o;
      end
    end
  end
endmodule : host_port_model
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk, rst, fe_n, en, serial_data_in, ifs, sclk, serial_data_out, ofs, cyc, stb, we, ack, go, rxv, sent;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, rd;
  logic [15:0] txw, rxw, last;
  int          mismatches, total_checks, gap;
  afe_serial_mode_control #(.DIVIDED_MASTER_CLOCK_DIV(4)) dut (.SYS_CLK_I(clk), .SYS_RST_I(rst),
    .FE_RESET_N_I(fe_n), .SERIAL_PORT_ENABLE_I(en), .SERIAL_DATA_IN_I(serial_data_in),
    .SERIAL_IN_FS_I(ifs), .SERIAL_CLK_O(sclk), .SERIAL_DATA_OUT_O(serial_data_out),
    .SERIAL_OUT_FS_O(ofs), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'h3), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack));
  host_port_model host (.clk_i(clk), .sclk_i(sclk), .fs_i(ofs), .sdo_i(serial_data_out), .go_i(go),
    .tx_i(txw), .sdi_o(serial_data_in), .ifs_o(ifs), .rx_valid_o(rxv), .sent_o(sent), .rx_o(rxw));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // watchdog sized well above the longest chain of sample periods
  initial begin
    #450000;
    mismatches++;
    stop_test();
  end
  task compare(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : compare
  // classic wishbone cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    {cyc, stb} <= 2'b00;
    if (n >= 20) mismatches++;
  endtask : wb
  task rd_reg(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    compare(rd, e);
  endtask : rd_reg
  // wait for the next word from the device; gap counts clocks waited in this call
  task rx_next;
    gap = 0;
    do begin @(posedge clk); gap++; end while (rxv !== 1'b1 && gap < 20000);
    if (gap >= 20000) mismatches++;
    last = rxw;
  endtask : rx_next
  // wait until the host model has shifted its word out
  task wait_sent;
    gap = 0;
    do begin @(posedge clk); gap++; end while (sent !== 1'b1 && gap < 20000);
    if (gap >= 20000) mismatches++;
  endtask : wait_sent
  task send(input logic [15:0] w);
    @(posedge clk);
    {go, txw} <= {1'b1, w};
    wait_sent();
    go <= 1'b0;
    rx_next();
  endtask : send
  task t_reset;
    rd_reg(8'h00, 32'h0);
    rd_reg(8'h04, 32'h0);
    rd_reg(8'h30, 32'h0);
    wb(1'b1, 8'h24, 32'hA5C3);
    rx_next();
    rx_next();
    compare(gap, 8192);
    compare(last, 32'hA5C3);
    $display("test reset done");
  endtask : t_reset
  task t_program;
    send(16'h0106);
    rd_reg(8'h04, 32'h06);
    rx_next();
    rx_next();
    compare(gap, 2048);
    send(16'h3155);
    compare(last, 32'h2155);
    $display("test program done");
  endtask : t_program
  task t_mixed;
    send(16'h0003);
    wb(1'b0, 8'h20, 32'h0);
    compare(rd[1:0], 2'b10);
    wb(1'b1, 8'h24, 32'hFFFF);
    rx_next();
    compare(last, 32'h7FFF);
    send(16'h8116);
    rd_reg(8'h04, 32'h16);
    send(16'h0107);
    rd_reg(8'h04, 32'h16);
    $display("test mixed done");
  endtask : t_mixed
  task t_data;
    send(16'h8001);
    wb(1'b0, 8'h20, 32'h0);
    compare(rd[1:0], 2'b01);
    send(16'h0100);
    send(16'h8100);
    rd_reg(8'h04, 32'h16);
    rd_reg(8'h00, 32'h01);
    $display("test data done");
  endtask : t_data
  task t_hw_reset;
    fe_n <= 1'b0;
    {go, txw} <= {1'b1, 16'h0106};
    repeat (40) @(posedge clk);
    fe_n <= 1'b1;
    wb(1'b0, 8'h20, 32'h0);
    compare(rd[4], 1'b1);
    repeat (30) @(posedge clk);
    rd_reg(8'h20, 32'h4);
    rd_reg(8'h04, 32'h0);
    wait_sent();
    txw <= 16'h0080;
    repeat (40) @(posedge clk);
    rd_reg(8'h04, 32'h06);
    wait_sent();
    go <= 1'b0;
    repeat (40) @(posedge clk);
    rd_reg(8'h04, 32'h0);
    $display("test hw reset done");
  endtask : t_hw_reset
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  initial begin
    {rst, fe_n, en, cyc, stb, we, go, adr, wdat, txw} = {3'b111, 4'h0, 8'h0, 32'h0, 16'h0};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_program();
    t_mixed();
    t_data();
    t_hw_reset();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
